// ---- shared/rsd_pkg.sv ----
/*
 * Package for the RS485 direction and error indicator block: register map,
 * field positions, reset values and timing counts.
 * Assumes a 200 MHz ref_clk and a word-wide AHB-Lite register port.
 */
package rsd_pkg;
    localparam int unsigned CLK_MHZ = 200;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_UPTIME = 8'h10;
    localparam logic [7:0] OFS_LOG_IDX = 8'h14;
    localparam logic [7:0] OFS_LOG_CODE = 8'h18;
    localparam logic [7:0] OFS_LOG_TIME = 8'h1c;
    // CTRL fields
    localparam int unsigned CTRL_MODE_485 = 0;
    localparam int unsigned CTRL_CONNECTED = 1;
    localparam int unsigned CTRL_SELFTEST_OK = 2;
    localparam int unsigned CTRL_SELFTEST_DONE = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Event bits (IRQ status / mask layout)
    localparam int unsigned EV_LINK = 0;
    localparam int unsigned EV_FORMAT = 1;
    localparam int unsigned EV_HSHAKE = 2;
    localparam int unsigned EV_SELFTEST = 3;
    localparam int unsigned EV_W = 4;
    // Fault codes kept in the history
    localparam logic [1:0] CODE_FORMAT = 2'h1;
    localparam logic [1:0] CODE_HSHAKE = 2'h2;
    // Indicator timing, in ms
    localparam int unsigned FLASH_ON_MS = 100;
    localparam int unsigned FLASH_GAP_MS = 200;
    localparam int unsigned GROUP_PAUSE_MS = 1200;
    localparam int unsigned ACT_PULSE_MS = 50;
    localparam int unsigned PERIOD_MS = 1000;
    localparam int unsigned MS_CYC = CLK_MHZ * 1000;
    localparam int unsigned FLASH_ON_CYC = FLASH_ON_MS * MS_CYC;
    localparam int unsigned FLASH_GAP_CYC = FLASH_GAP_MS * MS_CYC;
    localparam int unsigned GROUP_PAUSE_CYC = GROUP_PAUSE_MS * MS_CYC;
    localparam int unsigned ACT_PULSE_CYC = ACT_PULSE_MS * MS_CYC;
    localparam int unsigned PERIOD_CYC = PERIOD_MS * MS_CYC;
    localparam int unsigned LOG_DEPTH = 5;
endpackage

// ---- shared/rsd_flash_if.sv ----
/*
 * Interface between the top and the flash pattern generator.
 * Assumes both ends share ref_clk.
 */
`timescale 1ns/1ps
interface rsd_flash_if;
    logic [1:0] count;
    logic led;
    modport ctl (output count, input led);
    modport gen (input count, output led);
endinterface

// ---- hw/rsd_flasher.sv ----
/*
 * Error indicator flash generator: count flashes, then a long pause.
 * Assumes count is 0 for dark and 1..3 for the pattern; timing parameters.
 */
`timescale 1ns/1ps
module rsd_flasher #(
    parameter int unsigned ON_CYC = rsd_pkg::FLASH_ON_CYC,
    parameter int unsigned GAP_CYC = rsd_pkg::FLASH_GAP_CYC,
    parameter int unsigned PAUSE_CYC = rsd_pkg::GROUP_PAUSE_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    rsd_flash_if.gen fl
);
    typedef enum logic [1:0] {
        RSD_F_IDLE = 2'b00,
        RSD_F_ON = 2'b01,
        RSD_F_GAP = 2'b10,
        RSD_F_PAUSE = 2'b11
    } rsd_fstate_t;
    typedef struct packed {
        rsd_fstate_t st;
        logic [31:0] tmr;
        logic [1:0] left;
        logic led;
    } rsd_fl_t;
    rsd_fl_t q, d;

    // Flash sequencer; pause longer than gap keeps the count readable
    always_comb begin
        d = q;
        if (q.tmr != 32'h0) begin
            d.tmr = q.tmr - 32'h1;
        end
        case (q.st)
            RSD_F_IDLE: begin
                d.led = 1'b0;
                if (fl.count != 2'h0) begin
                    d.st = RSD_F_ON;
                    d.left = fl.count;
                    d.tmr = 32'(ON_CYC);
                    d.led = 1'b1;
                end
            end
            RSD_F_ON: begin
                if (q.tmr == 32'h0) begin
                    d.led = 1'b0;
                    d.left = q.left - 2'h1;
                    d.st = (q.left == 2'h1) ? RSD_F_PAUSE : RSD_F_GAP;
                    d.tmr = (q.left == 2'h1) ? 32'(PAUSE_CYC) : 32'(GAP_CYC);
                end
            end
            RSD_F_GAP: begin
                if (q.tmr == 32'h0) begin
                    d.st = RSD_F_ON;
                    d.led = 1'b1;
                    d.tmr = 32'(ON_CYC);
                end
            end
            default: begin
                if (q.tmr == 32'h0) begin
                    d.st = RSD_F_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign fl.led = q.led;
endmodule

// ---- hw/rsd_top.sv ----
/*
 * RS485 direction control, port routing and indicator logic with fault
 * history, registers over AHB-Lite.
 * Assumes a UART core beside it gives tx busy/start and rx event strobes,
 * all synchronous to ref_clk.
 */
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module rsd_top #(
    parameter int unsigned ON_CYC = rsd_pkg::FLASH_ON_CYC,
    parameter int unsigned GAP_CYC = rsd_pkg::FLASH_GAP_CYC,
    parameter int unsigned PAUSE_CYC = rsd_pkg::GROUP_PAUSE_CYC,
    parameter int unsigned ACT_CYC = rsd_pkg::ACT_PULSE_CYC,
    parameter int unsigned PER_CYC = rsd_pkg::PERIOD_CYC,
    parameter int unsigned MS_CYC = rsd_pkg::MS_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // UART side
    input wire logic uart_txd,
    input wire logic tx_start,
    input wire logic tx_busy,
    input wire logic rx_char,
    input wire logic rx_par_err,
    input wire logic rx_frm_err,
    input wire logic rx_overrun,
    input wire logic hs_stop,
    input wire logic link_ok,
    output logic uart_rxd,
    // Pins
    input wire logic ttl_rxd,
    input wire logic bus_rxd,
    output logic ttl_txd,
    output logic bus_txd,
    output logic bus_de,
    output logic bus_re_n,
    output logic led_status,
    output logic led_error,
    output logic led_power,
    output logic irq
);
    localparam int unsigned LD = rsd_pkg::LOG_DEPTH;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [rsd_pkg::EV_W-1:0] ist;
        logic [rsd_pkg::EV_W-1:0] imask;
        logic [2:0] lidx;
        logic dph;
        logic dwr;
        logic [7:0] daddr;
        logic [31:0] rdata;
        logic de;
        logic re_n;
        logic ttl_tx;
        logic bus_tx;
        logic rxd;
        logic [31:0] act_tmr;
        logic [31:0] per_tmr;
        logic [31:0] ms_tmr;
        logic [31:0] uptime;
        logic fail;
        logic sts;
        logic err;
        logic pwr;
        logic irq;
        logic [2:0] lwp;
        logic [4:0][1:0] codes;
        logic [4:0][31:0] times;
    } rsd_st_t;
    rsd_st_t q, d;

    rsd_flash_if fl ();
    logic fmt_err;
    logic hs_err;
    logic [2:0] ridx;

    rsd_flasher #(
        .ON_CYC(ON_CYC),
        .GAP_CYC(GAP_CYC),
        .PAUSE_CYC(PAUSE_CYC)
    ) u_flash (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .fl(fl)
    );

    // Format error covers parity, framing and overrun alike
    assign fmt_err = rx_char & (rx_par_err | rx_frm_err | rx_overrun);
    // Traffic after our stop signal is the remote's fault
    assign hs_err = rx_char & hs_stop;
    // Fixed priority: link, then format, then handshake
    assign fl.count = (!link_ok) ? 2'h1 : q.ist[rsd_pkg::EV_FORMAT] ? 2'h2 :
                      q.ist[rsd_pkg::EV_HSHAKE] ? 2'h3 : 2'h0;
    assign ridx = (q.lidx < 3'(LD)) ? q.lidx : 3'h0;

    always_comb begin
        logic mode485;
        logic run;
        logic [rsd_pkg::EV_W-1:0] ev;
        logic [rsd_pkg::EV_W-1:0] clr;
        mode485 = q.ctrl[rsd_pkg::CTRL_MODE_485];
        run = q.ctrl[rsd_pkg::CTRL_SELFTEST_DONE] & ~q.fail;
        ev = '0;
        clr = '0;
        d = q;

        // Bus slave: zero wait state, always OKAY
        d.dph = hsel & hready & htrans[1];
        d.dwr = hwrite;
        d.daddr = haddr;
        if (q.dph && q.dwr) begin
            if (q.daddr == rsd_pkg::OFS_CTRL) begin
                d.ctrl = hwdata;
            end else if (q.daddr == rsd_pkg::OFS_IRQ_STAT) begin
                clr = hwdata[rsd_pkg::EV_W-1:0];
            end else if (q.daddr == rsd_pkg::OFS_IRQ_MASK) begin
                d.imask = hwdata[rsd_pkg::EV_W-1:0];
            end else if (q.daddr == rsd_pkg::OFS_LOG_IDX) begin
                d.lidx = hwdata[2:0];
            end
        end
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr == rsd_pkg::OFS_CTRL) begin
                d.rdata = q.ctrl;
            end else if (haddr == rsd_pkg::OFS_STAT) begin
                d.rdata = {26'h0, q.fail, link_ok, q.re_n, q.de, q.sts, q.err};
            end else if (haddr == rsd_pkg::OFS_IRQ_STAT) begin
                d.rdata = {28'h0, q.ist};
            end else if (haddr == rsd_pkg::OFS_IRQ_MASK) begin
                d.rdata = {28'h0, q.imask};
            end else if (haddr == rsd_pkg::OFS_UPTIME) begin
                d.rdata = q.uptime;
            end else if (haddr == rsd_pkg::OFS_LOG_IDX) begin
                d.rdata = {29'h0, q.lidx};
            end else if (haddr == rsd_pkg::OFS_LOG_CODE) begin
                d.rdata = {30'h0, q.codes[ridx]};
            end else if (haddr == rsd_pkg::OFS_LOG_TIME) begin
                d.rdata = q.times[ridx];
            end else begin
                d.rdata = 32'h0;
            end
        end

        // Self-test failure latched once software reports it
        if (q.ctrl[rsd_pkg::CTRL_SELFTEST_DONE] && !q.ctrl[rsd_pkg::CTRL_SELFTEST_OK]
            && !q.fail) begin
            d.fail = 1'b1;
            ev[rsd_pkg::EV_SELFTEST] = 1'b1;
        end

        // Uptime in ms since reset, stamps the history
        d.ms_tmr = (q.ms_tmr == 32'h0) ? 32'(MS_CYC - 1) : q.ms_tmr - 32'h1;
        if (q.ms_tmr == 32'h0) begin
            d.uptime = q.uptime + 32'h1;
        end

        // Driver follows the transmitter: on at start, off when idle
        d.de = run & mode485 & (tx_start | tx_busy);
        d.re_n = run & mode485 & (tx_start | tx_busy);
        // Only the selected path moves, the other idles high
        d.ttl_tx = (run && !mode485) ? uart_txd : 1'b1;
        d.bus_tx = (run && mode485) ? uart_txd : 1'b1;
        // Own echo blocked while driving
        d.rxd = !run ? 1'b1 : !mode485 ? ttl_rxd : q.re_n ? 1'b1 : bus_rxd;

        if (run) begin
            ev[rsd_pkg::EV_LINK] = ~link_ok;
            ev[rsd_pkg::EV_FORMAT] = fmt_err;
            ev[rsd_pkg::EV_HSHAKE] = hs_err;
        end
        // History of serial faults, oldest overwritten
        if (run && (fmt_err || hs_err)) begin
            d.codes[q.lwp] = fmt_err ? rsd_pkg::CODE_FORMAT : rsd_pkg::CODE_HSHAKE;
            d.times[q.lwp] = q.uptime;
            d.lwp = (q.lwp == 3'(LD - 1)) ? 3'h0 : q.lwp + 3'h1;
        end
        // Set wins over write-one-to-clear
        d.ist = (q.ist & ~clr) | ev;
        d.irq = |(d.ist & q.imask);

        // Activity pulse and connection beacon
        if (run && (tx_start || rx_char)) begin
            d.act_tmr = 32'(ACT_CYC);
        end else if (q.act_tmr != 32'h0) begin
            d.act_tmr = q.act_tmr - 32'h1;
        end
        if (!q.ctrl[rsd_pkg::CTRL_CONNECTED] || q.per_tmr == 32'h0) begin
            d.per_tmr = 32'(PER_CYC - 1);
        end else begin
            d.per_tmr = q.per_tmr - 32'h1;
        end
        if (q.ctrl[rsd_pkg::CTRL_CONNECTED] && q.per_tmr == 32'h0 && run) begin
            d.act_tmr = 32'(ACT_CYC);
        end

        // Failed self-test: everything lit solid
        d.sts = q.fail | (q.act_tmr != 32'h0);
        d.err = q.fail | (run & fl.led);
        d.pwr = 1'b1;
        if (q.fail) begin
            d.de = 1'b0;
            d.re_n = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
            q.ctrl <= rsd_pkg::CTRL_RESET;
            q.re_n <= 1'b0;
            q.ttl_tx <= 1'b1;
            q.bus_tx <= 1'b1;
            q.rxd <= 1'b1;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign bus_de = q.de;
    assign bus_re_n = q.re_n;
    assign ttl_txd = q.ttl_tx;
    assign bus_txd = q.bus_tx;
    assign uart_rxd = q.rxd;
    assign led_status = q.sts;
    assign led_error = q.err;
    assign led_power = q.pwr;
    assign irq = q.irq;

    a_drv_rx_excl: assert property (@(posedge ref_clk) disable iff (srst)
        bus_de |-> bus_re_n) else $error("receiver open while driving");
    a_drv_follow_tx: assert property (@(posedge ref_clk) disable iff (srst)
        (clk_en && tx_start && q.ctrl[0] && q.ctrl[3] && !q.fail) |=> bus_de)
        else $error("driver not enabled on transmit");
    a_path_exclusive: assert property (@(posedge ref_clk) disable iff (srst)
        !(ttl_txd == 1'b0 && bus_txd == 1'b0)) else $error("both paths active");
    a_fail_all_on: assert property (@(posedge ref_clk) disable iff (srst)
        (clk_en && q.fail) |=> (led_status && led_error && led_power))
        else $error("self-test fail not shown");
    a_fmt_sticky: assert property (@(posedge ref_clk) disable iff (srst)
        (clk_en && fmt_err && q.ctrl[3] && !q.fail) |=> q.ist[1])
        else $error("format error not recorded");
    a_hs_sticky: assert property (@(posedge ref_clk) disable iff (srst)
        (clk_en && hs_err && q.ctrl[3] && !q.fail) |=> q.ist[2])
        else $error("handshake error not recorded");
    a_link_one: assert property (@(posedge ref_clk) disable iff (srst)
        !link_ok |-> fl.count == 2'h1) else $error("link pattern wrong");
    a_act_pulse: assert property (@(posedge ref_clk) disable iff (srst)
        (clk_en && rx_char && q.ctrl[3] && !q.fail) ##1 clk_en |=> led_status)
        else $error("no activity pulse");
endmodule

// ---- test/rsd_remote_model.sv ----
/*
 * Remote station on the 2-wire bus: sends one character frame on request.
 * Assumes send is a one-cycle pulse; rude makes it ignore the stop signal.
 */
`timescale 1ns/1ps
module rsd_remote_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic send,
    input wire logic rude,
    input wire logic hs_stop,
    input wire logic bus_de,
    output logic bus_rxd,
    output logic rx_char
);
    logic [3:0] cnt_q;
    logic pend_q;
    // A request waits while our driver owns the line or stop is raised
    always_ff @(posedge ref_clk) begin
        rx_char <= 1'b0;
        if (srst) begin
            cnt_q <= 4'h0;
            pend_q <= 1'b0;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            rx_char <= (cnt_q == 4'h1);
        end else if ((send || pend_q) && !bus_de && (!hs_stop || rude)) begin
            cnt_q <= 4'ha;
            pend_q <= 1'b0;
        end else if (send) begin
            pend_q <= 1'b1;
        end
    end
    // Terminated line rests high; frame alternates so stale levels show
    assign bus_rxd = (cnt_q == 4'h0) ? 1'b1 : cnt_q[0];
endmodule

// ---- test/rs485_direction_and_error_led_tb.sv ----
/*
 * Self-checking bench for the RS485 direction and indicator block.
 * Assumes shortened timing parameters and the remote model on the bus pins.
 */
`timescale 1ns/1ps
module rs485_direction_and_error_led_tb;
    logic ref_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic uart_txd = 1'b1, tx_start = 1'b0, tx_busy = 1'b0, rx_par_err = 1'b0;
    logic rx_frm_err = 1'b0, rx_overrun = 1'b0, hs_stop = 1'b0, link_ok = 1'b1;
    logic ttl_rxd = 1'b1, send = 1'b0, rude = 1'b0;
    logic hreadyout, hresp, uart_rxd, ttl_txd, bus_txd, bus_de, bus_re_n;
    logic led_status, led_error, led_power, irq, bus_rxd, rx_char;
    int mismatches = 0, checks = 0;
    logic clk_en = 1'b1;
    logic [2:0] hsize = 3'h0;
    // Shortened timing; the pause must outlast the 12-cycle dark test, the gap must not
    localparam int unsigned T_FL = 4;
    localparam int unsigned T_PAUSE = 20;
    localparam int unsigned T_ACT = 3;
    localparam int unsigned T_PER = 50;
    localparam int unsigned T_MS = 10;
    // Short counts keep the flash groups a few dozen cycles long
    rsd_top #(.ON_CYC(T_FL), .GAP_CYC(T_FL), .PAUSE_CYC(T_PAUSE), .ACT_CYC(T_ACT),
        .PER_CYC(T_PER), .MS_CYC(T_MS)) i_dut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .uart_txd(uart_txd), .tx_start(tx_start),
        .tx_busy(tx_busy), .rx_char(rx_char), .rx_par_err(rx_par_err),
        .rx_frm_err(rx_frm_err), .rx_overrun(rx_overrun), .hs_stop(hs_stop),
        .link_ok(link_ok), .uart_rxd(uart_rxd), .ttl_rxd(ttl_rxd), .bus_rxd(bus_rxd),
        .ttl_txd(ttl_txd), .bus_txd(bus_txd), .bus_de(bus_de), .bus_re_n(bus_re_n),
        .led_status(led_status), .led_error(led_error), .led_power(led_power),
        .irq(irq));
    rsd_remote_model i_rem (.ref_clk(ref_clk), .srst(srst), .send(send),
        .rude(rude), .hs_stop(hs_stop), .bus_de(bus_de), .bus_rxd(bus_rxd),
        .rx_char(rx_char));
    // Free-running clock, 5 ns period
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk1(string nm, logic e, logic g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkn(string nm, int e, int g);
        checks++;
        if (g != e) begin
            mismatches++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Bounded wait for hready; running out ends the run
    task automatic wt();
        int n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            if (++n > 50) begin
                mismatches++;
                end_sim();
            end
            @(posedge ref_clk);
        end
    endtask
    // One single word transfer: address phase, then data phase
    task automatic bus(logic w, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wt();
        rd = hrdata;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk32(nm, e, x);
    endtask
    // Flashes between two long dark spells; 12 dark cycles outlast a gap
    task automatic flashes(output int n);
        int lo = 0;
        int t = 0;
        logic prev = 1'b1;
        n = 0;
        for (int ph = 0; ph < 2; ph++) begin
            lo = 0;
            while (lo < 12) begin
                step(1);
                #1;
                if (ph == 1 && led_error && !prev) n++;
                prev = led_error;
                lo = led_error ? 0 : lo + 1;
                if (++t > 400) begin
                    mismatches++;
                    end_sim();
                end
            end
        end
        step(1);
    endtask
    task automatic t_reset();
        #1;
        chk1("led_power", 1'b1, led_power);
        chk1("irq idle", 1'b0, irq);
        chk1("bus_de idle", 1'b0, bus_de);
        step(1);
        rdc("ctrl reset", rsd_pkg::OFS_CTRL, 32'h0);
        rdc("unmapped", 8'h40, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_dir();
        wr(rsd_pkg::OFS_CTRL, 32'hd);
        tx_start <= 1'b1;
        tx_busy <= 1'b1;
        uart_txd <= 1'b0;
        step(1);
        tx_start <= 1'b0;
        step(2);
        #1;
        chk1("bus_de on", 1'b1, bus_de);
        chk1("bus_re_n off", 1'b1, bus_re_n);
        chk1("bus_txd data", 1'b0, bus_txd);
        chk1("ttl_txd idle", 1'b1, ttl_txd);
        chk1("tx status", 1'b1, led_status);
        step(1);
        tx_busy <= 1'b0;
        uart_txd <= 1'b1;
        // Enable low freezes the driver even though the shifter has emptied
        clk_en <= 1'b0;
        step(3);
        #1;
        chk1("bus_de frozen", 1'b1, bus_de);
        step(1);
        clk_en <= 1'b1;
        step(3);
        #1;
        chk1("bus_de off", 1'b0, bus_de);
        chk1("bus_re_n on", 1'b0, bus_re_n);
        $display("test direction done");
    endtask
    task automatic t_rx();
        logic z = 1'b0;
        logic s = 1'b0;
        step(1);
        send <= 1'b1;
        step(1);
        send <= 1'b0;
        repeat (16) begin
            step(1);
            #1;
            z |= !uart_rxd;
            s |= led_status;
        end
        chk1("rx passes", 1'b1, z);
        chk1("rx status", 1'b1, s);
        step(1);
        wr(rsd_pkg::OFS_CTRL, 32'hc);
        ttl_rxd <= 1'b0;
        tx_start <= 1'b1;
        tx_busy <= 1'b1;
        uart_txd <= 1'b0;
        step(1);
        tx_start <= 1'b0;
        step(2);
        #1;
        chk1("ttl_txd", 1'b0, ttl_txd);
        chk1("bus_txd idle", 1'b1, bus_txd);
        chk1("bus_de ttl", 1'b0, bus_de);
        chk1("uart_rxd ttl", 1'b0, uart_rxd);
        step(1);
        tx_busy <= 1'b0;
        uart_txd <= 1'b1;
        ttl_rxd <= 1'b1;
        wr(rsd_pkg::OFS_CTRL, 32'hf);
        z = 1'b0;
        repeat (120) begin
            step(1);
            #1;
            z |= led_status;
        end
        chk1("periodic status", 1'b1, z);
        step(1);
        wr(rsd_pkg::OFS_CTRL, 32'hd);
        $display("test rx and routing done");
    endtask
    task automatic t_err();
        int n;
        link_ok <= 1'b0;
        flashes(n);
        chkn("link flashes", 1, n);
        link_ok <= 1'b1;
        // Link bit is sticky; clear it so later status reads see one event
        rdc("link status", rsd_pkg::OFS_IRQ_STAT, 32'h1);
        wr(rsd_pkg::OFS_IRQ_STAT, 32'h1);
        for (int k = 0; k < 3; k++) begin
            {rx_overrun, rx_frm_err, rx_par_err} <= 3'h1 << k;
            send <= 1'b1;
            step(1);
            send <= 1'b0;
            step(14);
            {rx_overrun, rx_frm_err, rx_par_err} <= 3'h0;
            flashes(n);
            chkn("format flashes", 2, n);
            rdc("format status", rsd_pkg::OFS_IRQ_STAT, 32'h2);
            // irq follows a new mask one cycle after the write lands
            wr(rsd_pkg::OFS_IRQ_MASK, 32'h0);
            step(1);
            #1;
            chk1("irq masked", 1'b0, irq);
            step(1);
            wr(rsd_pkg::OFS_IRQ_MASK, 32'hf);
            step(1);
            #1;
            chk1("irq mask", 1'b1, irq);
            step(1);
            wr(rsd_pkg::OFS_IRQ_STAT, 32'h2);
            #1;
            chk1("irq cleared", 1'b0, irq);
            step(1);
        end
        hs_stop <= 1'b1;
        send <= 1'b1;
        step(1);
        send <= 1'b0;
        step(20);
        rdc("polite remote", rsd_pkg::OFS_IRQ_STAT, 32'h0);
        rude <= 1'b1;
        step(14);
        rude <= 1'b0;
        flashes(n);
        chkn("handshake flashes", 3, n);
        link_ok <= 1'b0;
        flashes(n);
        chkn("one pattern", 1, n);
        link_ok <= 1'b1;
        hs_stop <= 1'b0;
        $display("test error patterns done");
    endtask
    task automatic t_log();
        logic [31:0] x;
        for (int i = 0; i < 5; i++) begin
            wr(rsd_pkg::OFS_LOG_IDX, i);
            rdc("log code", rsd_pkg::OFS_LOG_CODE, i < 3 ? 32'h1 : i == 3 ? 32'h2 : 32'h0);
        end
        wr(rsd_pkg::OFS_LOG_IDX, 32'h3);
        bus(1'b0, rsd_pkg::OFS_LOG_TIME, 32'h0, x);
        chk1("log time", 1'b1, x != 32'h0);
        $display("test history done");
    endtask
    task automatic t_fail();
        srst <= 1'b1;
        step(2);
        srst <= 1'b0;
        step(1);
        wr(rsd_pkg::OFS_CTRL, 32'h9);
        tx_start <= 1'b1;
        tx_busy <= 1'b1;
        step(1);
        tx_start <= 1'b0;
        step(30);
        #1;
        chk1("fail power", 1'b1, led_power);
        chk1("fail status", 1'b1, led_status);
        chk1("fail error", 1'b1, led_error);
        chk1("fail dead", 1'b0, bus_de);
        step(1);
        tx_busy <= 1'b0;
        $display("test selftest done");
    endtask
    // Main sequence: reset for 8 cycles, then each scenario
    initial begin
        step(8);
        srst <= 1'b0;
        step(1);
        t_reset();
        t_dir();
        t_rx();
        t_err();
        t_log();
        t_fail();
        end_sim();
    end
endmodule
